// ### rtl/pfs_pkg.sv
// constants and types for the fiber detect, strap report and led config slice
// assumes a 16-bit register port with word addresses as printed
package pfs_pkg;
   // ***********************************
   // register offsets
   // ***********************************
   localparam logic [15:0] ADDR_FIBER_CFG = 16'h0465; // fiber_general_config
   localparam logic [15:0] ADDR_STRAP_ONE = 16'h0467; // strap_latch_status_one
   localparam logic [15:0] ADDR_STRAP_TWO = 16'h0468; // strap_latch_status_two
   localparam logic [15:0] ADDR_LED_CFG   = 16'h0469; // led_pin_config_two
   // ***********************************
   // reset values and write masks
   // ***********************************
   localparam logic [15:0] FIBER_CFG_RST  = 16'hff00; // upper bits reset high
   localparam logic [15:0] LED_CFG_RST    = 16'h0040; // third led active high
   localparam logic [15:0] LED_CFG_WMASK  = 16'h0770; // writable led bits
   localparam logic [15:0] RD_UNMAPPED    = 16'h0000; // answer off the map
   // ***********************************
   // field positions
   // ***********************************
   localparam int FIBER_POL_BIT = 0;  // signal detect polarity
   localparam int LED1_POL_BIT  = 10; // first led pin polarity
   localparam int LED1_VAL_BIT  = 9;  // first led force level
   localparam int LED1_EN_BIT   = 8;  // first led force enable
   localparam int LED3_POL_BIT  = 6;  // third led polarity
   localparam int LED3_VAL_BIT  = 5;  // data bit 3 force level
   localparam int LED3_EN_BIT   = 4;  // data bit 3 force enable
   localparam int S1_RXD1_LSB   = 14; // mode field positions, word one
   localparam int S1_RXD0_LSB   = 12;
   localparam int S1_COL_LSB    = 10;
   localparam int S1_RXER_LSB   = 8;
   localparam int S1_CRS_LSB    = 6;
   localparam int S1_RXDV_LSB   = 4;
   localparam int S1_LED0_LSB   = 0;
   localparam int S2_RXD3_LSB   = 2;  // mode field positions, word two
   localparam int S2_RXD2_LSB   = 0;
   localparam int SYNC_STAGES   = 2;  // flops on every pin input
   // ***********************************
   // types
   // ***********************************
   // strap modes as sensed by the pads: 00..11 are modes 1..4
   typedef struct packed {
      logic [1:0] rxd1;      // receive data bit 1 pin
      logic [1:0] rxd0;      // receive data bit 0 pin
      logic [1:0] col;       // collision pin
      logic [1:0] rx_er;     // receive error pin
      logic [1:0] crs;       // carrier sense pin
      logic [1:0] rx_dv;     // receive valid pin
      logic [1:0] led0;      // indicator pin zero
      logic [1:0] rxd3;      // receive data bit 3 pin
      logic [1:0] rxd2;      // receive data bit 2 pin
      logic       fiber_detect_strap_enable;     // fiber_detect_strap_enable
      logic       led1_pull; // pull seen on indicator pin one
   } pfs_strap_t;
   typedef struct packed {
      logic [15:0] addr;  // register offset
      logic [15:0] wdata; // write data
      logic        wr;    // write strobe
      logic        rd;    // read strobe
   } pfs_bus_t;
   // strap capture sequencer, one-hot
   typedef enum logic [3:0] {
      ST_WAIT1 = 4'b0001, // reset just released
      ST_WAIT2 = 4'b0010, // synchronisers filling
      ST_CAPT  = 4'b0100, // latch straps
      ST_RUN   = 4'b1000  // normal operation
   } pfs_state_t;
endpackage

// ### rtl/pfs_fiber_strap_led.sv
// fiber signal detect, strap latch report and led pin control slice
// assumes pads resolve the two-way pins from out and oe, and that the
// pads report nine straps as two-bit mode codes and two as single bits until they are latched
`timescale 1ns/1ps
module pfs_fiber_strap_led #(
   parameter int ADDR_W = 16 // register address width
) (
   input  wire logic               mclk,          // 40 MHz clock
   input  wire logic               rst_n,         // async reset, active low
   input  wire pfs_pkg::pfs_bus_t  bus,           // register port request
   output logic [15:0]             reg_rdata,     // read data, cycle after rd
   input  wire pfs_pkg::pfs_strap_t strap_pins,   // strap codes from the pads
   input  wire logic               indicator_pin_one_in,   // pad level
   output logic                    indicator_pin_one_out,  // pad drive level
   output logic                    indicator_pin_one_oe,   // pad drive enable
   output logic                    receive_data_bit3_pin_out, // pad level
   output logic                    receive_data_bit3_pin_oe,  // pad enable
   input  wire logic               led1_func,     // led one status, same clock
   input  wire logic               led3_func,     // led three status
   output logic                    fiber_link_drop // 100 Mbps fiber link down
);
   // ***********************************
   // elaboration checks
   // ***********************************
   // offsets need eleven address bits, and the port carries sixteen
   if (ADDR_W < 11 || ADDR_W > 16) begin : g_bad_addr
      $error("pfs: ADDR_W outside 11 to 16 for the register map");
   end

   // ***********************************
   // reset release
   // ***********************************
   logic [1:0] rst_pipe; // release synchroniser
   logic       rst_s_n;  // reset used everywhere else

   // assert at once, release after two edges
   // a release close to an edge must not leave half the flops in reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_s_n = rst_pipe[1];

   // ***********************************
   // pin input synchronisers
   // ***********************************
   localparam int IN_W = $bits(pfs_pkg::pfs_strap_t) + 1; // straps + pin
   logic [IN_W-1:0] sync_a;      // first stage, read only by sync_b
   logic [IN_W-1:0] sync_b;      // second stage
   pfs_pkg::pfs_strap_t strap_s; // synchronised strap codes
   logic fiber_signal_detect_in; // synchronised detect level

   // straps and the detect pin move at any time against mclk; two stages
   // keep a metastable level away from the capture and the drop logic
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {strap_pins, indicator_pin_one_in};
         sync_b <= sync_a;
      end
   end
   assign strap_s                = pfs_pkg::pfs_strap_t'(sync_b[IN_W-1:1]);
   assign fiber_signal_detect_in = sync_b[0];

   // ***********************************
   // strap capture
   // ***********************************
   pfs_pkg::pfs_state_t state;      // capture sequencer
   pfs_pkg::pfs_state_t next_state;
   pfs_pkg::pfs_strap_t strap_lat;  // straps held until next reset
   pfs_pkg::pfs_strap_t next_strap_lat;
   logic                run;        // pins released to normal use

   // wait for the synchronisers to fill, latch once, then hold
   always_comb begin
      next_state     = state;
      next_strap_lat = strap_lat;
      case (state)
         pfs_pkg::ST_WAIT1: begin
            next_state = pfs_pkg::ST_WAIT2;
         end
         pfs_pkg::ST_WAIT2: begin
            next_state = pfs_pkg::ST_CAPT;
         end
         pfs_pkg::ST_CAPT: begin
            next_strap_lat = strap_s;
            next_state     = pfs_pkg::ST_RUN;
         end
         pfs_pkg::ST_RUN: begin
            next_state = pfs_pkg::ST_RUN; // no exit but reset
         end
         default: begin
            next_state = pfs_pkg::ST_WAIT1;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state     <= pfs_pkg::ST_WAIT1;
         strap_lat <= '0;
      end else begin
         state     <= next_state;
         strap_lat <= next_strap_lat;
      end
   end
   assign run = (state == pfs_pkg::ST_RUN);

   // ***********************************
   // writable registers
   // ***********************************
   logic [15:0] fiber_cfg;      // fiber_general_config
   logic [15:0] next_fiber_cfg;
   logic [15:0] led_cfg;        // led_pin_config_two
   logic [15:0] next_led_cfg;
   logic        wr_ok;          // any write strobe, no range test

   // only writable bits change; the status words take no write
   always_comb begin
      // offsets decode all sixteen bits below, so no range test is needed
      wr_ok          = bus.wr;
      next_fiber_cfg = fiber_cfg;
      next_led_cfg   = led_cfg;
      if (wr_ok && bus.addr == pfs_pkg::ADDR_FIBER_CFG) begin
         next_fiber_cfg = bus.wdata;
      end
      if (wr_ok && bus.addr == pfs_pkg::ADDR_LED_CFG) begin
         next_led_cfg = (bus.wdata & pfs_pkg::LED_CFG_WMASK)
                      | (led_cfg & ~pfs_pkg::LED_CFG_WMASK);
      end
      // the strapped pull wins over a write in the capture cycle
      if (state == pfs_pkg::ST_CAPT) begin
         next_led_cfg[pfs_pkg::LED1_POL_BIT] = strap_s.led1_pull;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         fiber_cfg <= pfs_pkg::FIBER_CFG_RST;
         led_cfg   <= pfs_pkg::LED_CFG_RST;
      end else begin
         fiber_cfg <= next_fiber_cfg;
         led_cfg   <= next_led_cfg;
      end
   end

   // ***********************************
   // status words
   // ***********************************
   logic [15:0] strap_word_one; // strap_latch_status_one
   logic [15:0] strap_word_two; // strap_latch_status_two

   // mode codes pass as latched; bits between fields read zero
   always_comb begin
      strap_word_one = '0;
      strap_word_one[pfs_pkg::S1_RXD1_LSB +: 2] = strap_lat.rxd1;
      strap_word_one[pfs_pkg::S1_RXD0_LSB +: 2] = strap_lat.rxd0;
      strap_word_one[pfs_pkg::S1_COL_LSB  +: 2] = strap_lat.col;
      strap_word_one[pfs_pkg::S1_RXER_LSB +: 2] = strap_lat.rx_er;
      strap_word_one[pfs_pkg::S1_CRS_LSB  +: 2] = strap_lat.crs;
      strap_word_one[pfs_pkg::S1_RXDV_LSB +: 2] = strap_lat.rx_dv;
      strap_word_one[pfs_pkg::S1_LED0_LSB +: 2] = strap_lat.led0;
      strap_word_two = '0;
      strap_word_two[pfs_pkg::S2_RXD3_LSB +: 2] = strap_lat.rxd3;
      strap_word_two[pfs_pkg::S2_RXD2_LSB +: 2] = strap_lat.rxd2;
   end

   // ***********************************
   // read port
   // ***********************************
   logic [15:0] next_rdata; // data for the cycle after rd

   // data stands only in the cycle after the strobe, else zero
   // zero between reads keeps a stale word from passing as an answer
   always_comb begin
      next_rdata = '0;
      if (bus.rd) begin
         case (bus.addr)
            pfs_pkg::ADDR_FIBER_CFG: next_rdata = fiber_cfg;
            pfs_pkg::ADDR_STRAP_ONE: next_rdata = strap_word_one;
            pfs_pkg::ADDR_STRAP_TWO: next_rdata = strap_word_two;
            pfs_pkg::ADDR_LED_CFG:   next_rdata = led_cfg;
            default:                 next_rdata = pfs_pkg::RD_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // ***********************************
   // fiber detect and pin drive
   // ***********************************
   logic sd_pol_low;     // detect treated as active low
   logic sd_on;          // pin one serves as detect input
   logic next_drop;
   logic next_p1_out;
   logic next_p1_oe;
   logic next_p3_out;
   logic next_p3_oe;

   // pins stay released until straps are latched, so pulls can be sensed
   always_comb begin
      sd_pol_low  = fiber_cfg[pfs_pkg::FIBER_POL_BIT];
      sd_on       = run && strap_lat.fiber_detect_strap_enable;
      next_drop   = 1'b0;
      if (sd_on) begin
         // drop while the sampled detect is at its inactive level
         next_drop = sd_pol_low ? fiber_signal_detect_in
                                : !fiber_signal_detect_in;
      end
      // pin one: input when strapped for detect, else led output
      // a forced level ignores polarity: software asks for a pad level
      next_p1_oe  = run && !strap_lat.fiber_detect_strap_enable;
      if (led_cfg[pfs_pkg::LED1_EN_BIT]) begin
         next_p1_out = led_cfg[pfs_pkg::LED1_VAL_BIT];
      end else begin
         next_p1_out = led_cfg[pfs_pkg::LED1_POL_BIT] ? led1_func
                                                      : !led1_func;
      end
      // data bit 3 pin: led three or forced level
      next_p3_oe  = run;
      if (led_cfg[pfs_pkg::LED3_EN_BIT]) begin
         next_p3_out = led_cfg[pfs_pkg::LED3_VAL_BIT];
      end else begin
         next_p3_out = led_cfg[pfs_pkg::LED3_POL_BIT] ? led3_func
                                                      : !led3_func;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         fiber_link_drop           <= 1'b0;
         indicator_pin_one_out     <= 1'b0;
         indicator_pin_one_oe      <= 1'b0;
         receive_data_bit3_pin_out <= 1'b0;
         receive_data_bit3_pin_oe  <= 1'b0;
      end else begin
         fiber_link_drop           <= next_drop;
         indicator_pin_one_out     <= next_p1_out;
         indicator_pin_one_oe      <= next_p1_oe;
         receive_data_bit3_pin_out <= next_p3_out;
         receive_data_bit3_pin_oe  <= next_p3_oe;
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_s_n);

   // capture step followed by the strapped polarity in the register
   sequence s_capture;
      state == pfs_pkg::ST_CAPT;
   endsequence
   sequence s_pol_loaded;
      led_cfg[pfs_pkg::LED1_POL_BIT] == $past(strap_s.led1_pull);
   endsequence
   // a read of word one once the straps are latched
   sequence s_read_one;
      bus.rd && bus.addr == pfs_pkg::ADDR_STRAP_ONE && run;
   endsequence

   a_pol_reset_zero: assert property (
      $rose(rst_s_n) |-> fiber_cfg[pfs_pkg::FIBER_POL_BIT] == 1'b0)
      else $error("detect polarity not active high after reset");
   a_drop_active_high: assert property (
      sd_on && !sd_pol_low && !fiber_signal_detect_in |=> fiber_link_drop)
      else $error("link kept with low detect, active high");
   a_drop_active_low: assert property (
      sd_on && sd_pol_low |=> fiber_link_drop == $past(fiber_signal_detect_in))
      else $error("link drop wrong with active low detect");
   a_no_detect_pin: assert property (
      run && !strap_lat.fiber_detect_strap_enable |=> !fiber_link_drop && indicator_pin_one_oe)
      else $error("detect used without strap enable");
   a_strap_one_read: assert property (
      bus.rd && bus.addr == pfs_pkg::ADDR_STRAP_ONE && run
      |=> reg_rdata[15:14] == strap_lat.rxd1 && reg_rdata[3:2] == 2'b00)
      else $error("strap word one read wrong");
   a_strap_two_read: assert property (
      bus.rd && bus.addr == pfs_pkg::ADDR_STRAP_TWO
      |=> reg_rdata == {12'h000, strap_lat.rxd3, strap_lat.rxd2})
      else $error("strap word two read wrong");
   a_led1_pol_strap: assert property (
      s_capture |=> s_pol_loaded)
      else $error("pin one polarity not loaded from pull");
   a_led1_force: assert property (
      led_cfg[pfs_pkg::LED1_EN_BIT]
      |=> indicator_pin_one_out == $past(led_cfg[pfs_pkg::LED1_VAL_BIT]))
      else $error("pin one force level not driven");
   a_rxd3_force: assert property (
      led_cfg[pfs_pkg::LED3_EN_BIT]
      |=> receive_data_bit3_pin_out == $past(led_cfg[pfs_pkg::LED3_VAL_BIT]))
      else $error("data bit 3 force level not driven");
   a_strap_hold: assert property (
      run |=> run && $stable(strap_lat))
      else $error("strap latch changed after capture");

   // lower strap fields, normal pin levels, pin release and fiber config writes
   a_strap_one_rest: assert property (
      s_read_one
      |=> reg_rdata[13:12] == strap_lat.rxd0 && reg_rdata[11:10] == strap_lat.col
          && reg_rdata[9:8] == strap_lat.rx_er && reg_rdata[7:6] == strap_lat.crs
          && reg_rdata[5:4] == strap_lat.rx_dv && reg_rdata[1:0] == strap_lat.led0)
      else $error("strap word one lower fields wrong");
   a_led1_normal: assert property (
      !led_cfg[pfs_pkg::LED1_EN_BIT]
      |=> indicator_pin_one_out
          == ($past(led_cfg[pfs_pkg::LED1_POL_BIT]) ? $past(led1_func) : !$past(led1_func)))
      else $error("pin one level not in the set polarity");
   a_rxd3_normal: assert property (
      !led_cfg[pfs_pkg::LED3_EN_BIT]
      |=> receive_data_bit3_pin_out
          == ($past(led_cfg[pfs_pkg::LED3_POL_BIT]) ? $past(led3_func) : !$past(led3_func)))
      else $error("data bit 3 level not in the set polarity");
   a_pins_released: assert property (
      !run |=> !indicator_pin_one_oe && !receive_data_bit3_pin_oe)
      else $error("pin driven before straps were latched");
   a_fiber_cfg_write: assert property (
      bus.wr && bus.addr == pfs_pkg::ADDR_FIBER_CFG |=> fiber_cfg == $past(bus.wdata))
      else $error("fiber config write not taken");
endmodule

// ### testbench/pfs_sd_xcvr.sv
// model of the optical transceiver that drives the fiber signal detect line
// assumes one bench clock; the detect output is driven at all times
`timescale 1ns/1ps
module pfs_sd_xcvr (
   input  wire logic       mclk,    // bench clock
   input  wire logic       light,   // optical power present on the fiber
   input  wire logic       act_low, // part flavour: detect reported active low
   input  wire logic [1:0] lag,     // response delay in cycles, 0 = prompt
   output logic            sd_out   // signal detect output
);
   // ***********************************
   // delay line
   // ***********************************
   logic [2:0] pipe = 3'h0; // past detect levels, newest in bit 0
   // a slow part answers late, so the block must not lean on a fixed latency
   always_ff @(posedge mclk) begin
      pipe <= {pipe[1:0], light ^ act_low};
   end
   assign sd_out = (lag == 2'd0) ? (light ^ act_low) : pipe[lag - 2'd1];
endmodule

// ### testbench/testbench.sv
// self-checking bench for the fiber detect, strap report and led slice
// assumes the pads resolve pin one from oe; the transceiver drives it otherwise
`timescale 1ns/1ps
module testbench;
   // ***********************************
   // signals
   // ***********************************
   logic               mclk = 1'b0;         // 40 MHz clock
   logic               rst_n = 1'b0;        // reset, active low
   pfs_pkg::pfs_bus_t  bus = '0;            // register requests
   logic [15:0]        reg_rdata;           // read data
   pfs_pkg::pfs_strap_t straps = '0;        // strap codes at the pads
   pfs_pkg::pfs_strap_t s;                  // copy used for expectations
   logic               pin1_in, pin1_out, pin1_oe, rxd3_out, rxd3_oe, drop;
   logic               led1_func = 1'b0;    // led one status
   logic               led3_func = 1'b0;    // led three status
   logic               light = 1'b0;        // optical power
   logic               xlow = 1'b0;         // transceiver flavour
   logic [1:0]         lag = 2'd0;          // transceiver delay
   logic               sd;                  // transceiver detect output
   logic [31:0]        seed = 32'h373d_6e44; // fixed seed, repeatable run
   int                 mismatches = 0;      // failed comparisons
   int                 total_checks = 0;    // comparisons made
   // the wire: the block wins while it drives, else the transceiver
   assign pin1_in = pin1_oe ? pin1_out : sd;
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   pfs_fiber_strap_led pfs_fiber_strap_led_inst (
      .mclk(mclk), .rst_n(rst_n), .bus(bus), .reg_rdata(reg_rdata), .strap_pins(straps),
      .indicator_pin_one_in(pin1_in), .indicator_pin_one_out(pin1_out),
      .indicator_pin_one_oe(pin1_oe), .receive_data_bit3_pin_out(rxd3_out),
      .receive_data_bit3_pin_oe(rxd3_oe), .led1_func(led1_func), .led3_func(led3_func),
      .fiber_link_drop(drop));
   pfs_sd_xcvr pfs_sd_xcvr_inst (
      .mclk(mclk), .light(light), .act_low(xlow), .lag(lag), .sd_out(sd));
   // ***********************************
   // helpers
   // ***********************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // forced level wins, else status shown in the selected polarity
   function automatic logic pin_exp(input logic frc, val, pol, func);
      return frc ? val : (pol ? func : ~func);
   endfunction
   function automatic logic [15:0] word_one(input pfs_pkg::pfs_strap_t t);
      return {t.rxd1, t.rxd0, t.col, t.rx_er, t.crs, t.rx_dv, 2'b00, t.led0};
   endfunction
   task automatic chk(input logic [15:0] seen, exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // one write cycle, then an idle cycle so strobes never collide
   task automatic wr(input logic [15:0] a, d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
   endtask
   // data stand in the cycle after the strobe only; taken at the edge closing it
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
      @(posedge mclk);
      d = reg_rdata;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // ***********************************
   // tests
   // ***********************************
   initial begin
      repeat (6000) @(posedge mclk);
      mismatches++;
      give_verdict();
   end
   initial begin
      logic [15:0] d, v;
      logic        f1, f3;
      logic [31:0] r;     // one random draw
      for (int sden = 0; sden < 2; sden++) begin
         // straps only change while reset holds, a second pass resets mid-run
         @(posedge mclk);
         rst_n <= 1'b0;
         r = xs();
         s = pfs_pkg::pfs_strap_t'(r[19:0]);
         s.fiber_detect_strap_enable = sden[0];
         straps <= s;
         repeat (8) @(posedge mclk);
         rst_n <= 1'b1;
         repeat (8) @(posedge mclk);
         rd(pfs_pkg::ADDR_FIBER_CFG, d);
         chk(d, pfs_pkg::FIBER_CFG_RST, "fiber reset");
         rd(pfs_pkg::ADDR_LED_CFG, d);
         chk(d, pfs_pkg::LED_CFG_RST | {5'h00, s.led1_pull, 10'h000}, "led reset");
         for (int w = 0; w < 2; w++) begin
            rd(pfs_pkg::ADDR_STRAP_ONE, d);
            chk(d, word_one(s), "strap one");
            rd(pfs_pkg::ADDR_STRAP_TWO, d);
            chk(d, {12'h000, s.rxd3, s.rxd2}, "strap two");
            wr(pfs_pkg::ADDR_STRAP_ONE, ~word_one(s));
            wr(pfs_pkg::ADDR_STRAP_TWO, 16'hffff);
         end
         wr(16'h0466, 16'hffff);
         rd(16'h0466, d);
         chk(d, pfs_pkg::RD_UNMAPPED, "unmapped");
         // led config: all ones, all zeros, then random words
         for (int i = 0; i < 8; i++) begin
            r  = xs();
            v  = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : r[31:16];
            f1 = r[0];
            f3 = r[1];
            led1_func <= f1;
            led3_func <= f3;
            wr(pfs_pkg::ADDR_LED_CFG, v);
            rd(pfs_pkg::ADDR_LED_CFG, d);
            chk(d, v & pfs_pkg::LED_CFG_WMASK, "led cfg");
            @(posedge mclk);
            chk(rxd3_out, pin_exp(v[4], v[5], v[6], f3), "data bit 3 pin");
            chk(rxd3_oe, 1'b1, "data bit 3 enable");
            chk(pin1_oe, !sden[0], "pin one enable");
            if (!sden[0])
               chk(pin1_out, pin_exp(v[8], v[9], v[10], f1), "pin one level");
         end
         // fiber detect in both polarities against a prompt or slow part
         for (int p = 0; p < 2; p++) begin
            v = 16'(xs());
            wr(pfs_pkg::ADDR_FIBER_CFG, v);
            rd(pfs_pkg::ADDR_FIBER_CFG, d);
            chk(d, v, "fiber cfg");
            wr(pfs_pkg::ADDR_FIBER_CFG, {15'h7f80, p[0]});
            for (int k = 0; k < 8; k++) begin
               v = 16'(xs());
               @(posedge mclk);
               light <= v[0];
               xlow <= v[1];
               lag <= v[3:2] % 2'd3 + 2'(k % 2);
               repeat (10) @(posedge mclk);
               chk(drop, sden[0] & (p[0] ? sd : ~sd), "link drop");
            end
         end
         $display("test pass with strap enable %0d done", sden);
      end
      give_verdict();
   end
endmodule
